// >>> lbpc_pkg.sv
package lbpc_pkg;

	// ----------------------------------------------------------------
	// Register indices (printed offsets are not all multiples of
	// four, so each is an index and the byte address is four times it).
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_MAIN_CFG = 8'h95;
	localparam logic [7:0] IDX_CLK_CFG = 8'h96;
	localparam logic [7:0] IDX_SEG_EN_A = 8'h97;
	localparam logic [7:0] IDX_VOLT_CFG = 8'h9c;
	localparam logic [7:0] IDX_SEG_PTR = 8'hac;
	localparam logic [7:0] IDX_SEG_DATA = 8'hae;
	localparam logic [7:0] IDX_FREEZE = 8'hb1;
	localparam logic [7:0] IDX_SEG_EN_B = 8'hed;
	localparam logic [7:0] IDX_POWER_CFG = 8'hf4;
	localparam logic [7:0] IDX_STATUS = 8'hf8;

	// ----------------------------------------------------------------
	// Field positions.
	// ----------------------------------------------------------------
	localparam int BIT_EXT_LADDER = 6;
	localparam int BIT_SLEEP_BLOCK = 4;
	localparam int BIT_DISP_EN = 7;
	localparam int BIT_REF_KEEP = 3;
	localparam int BIT_PTR_WRITE = 7;
	localparam int BIT_FREEZE = 0;
	localparam int CONTRAST_W = 6;
	localparam int BIT_BIAS_THIRD = 6;
	localparam int FRAME_DIV_LSB = 0;
	localparam int FRAME_DIV_W = 4;

	// ----------------------------------------------------------------
	// Reset values and sizes.
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int MEM_DEPTH = 15;
	localparam int FIXED_SEGS = 16;
	localparam int TOTAL_SEGS = 29;
	localparam int SEG_EN_BITS = 13;
	localparam logic [1:0] MUX_FOUR = 2'h3;
	localparam int LMUX_LSB = 0;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Bias rail outputs travel together.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [9:0] rail_a;
		logic [9:0] rail_b;
		logic [9:0] rail_c;
	} lbpc_rails_s;

	typedef enum logic [1:0] {
		LBPC_IDLE,
		LBPC_ACK
	} lbpc_bus_e;

endpackage : lbpc_pkg

// >>> lbpc_rail_calc.sv
// ------------------------------------------------------------------
// Bias rail arithmetic.
// ------------------------------------------------------------------
module lbpc_rail_calc #(
	parameter int REF_W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [REF_W-1:0] vref_code,
	input wire logic [5:0] contrast,
	input wire logic third_bias,
	input wire logic run,
	output lbpc_pkg::lbpc_rails_s rails
);

	// The product below is sized for a reference code of eight bits.
	if (REF_W < 1 || REF_W > 8) begin : g_ref_w_check
		$error("REF_W out of range");
	end

	logic [15:0] prod;
	logic [9:0] top;

	// Top rail scales reference by the contrast code plus one step. The
	// product keeps full width, so no contrast code wraps the rail to zero.
	always_comb begin
		prod = 16'(vref_code) * (16'(contrast) + 16'h0001);
		top = 10'(prod >> 6);
	end

	// Rails drop to zero when generation stops, so no charge is drawn.
	always_ff @(posedge clk) begin
		if (!rst_n || !run) begin
			rails <= '0;
		end else if (third_bias) begin
			rails.rail_c <= top; // R2
			rails.rail_b <= 10'((top * 10'h002) / 10'h003);
			rails.rail_a <= 10'(top / 10'h003);
		end else begin
			rails.rail_c <= top; // R2
			rails.rail_b <= 10'(top >> 1);
			rails.rail_a <= 10'(top >> 1);
		end
	end

endmodule : lbpc_rail_calc

// >>> lbpc_core.sv
// Contract
// R1: Charge pump offers 64 contrast levels from six-bit field.
// R2: Rails derive from reference, contrast field and bias fraction.
// R3: Ladder select bit six resets to zero, selecting charge pump.
// R4: With ladder selected, internal contrast has no effect on drive.
// R5: In deepest sleep display on only when block bit 0, enable 1.
// R6: Software sets reference keepalive bit before expecting sleep display.
// R7: Settings and segment memory kept while display is off.
// R8: First sixteen segment pins always display pins.
// R9: Four-way mux uses all commons; shared pins act as commons.
// R10: Higher segment pins become display only when enable bit set.
// R11: 2048 Hz clock, four-way mux, divider all ones gives 64 Hz.
// R12: Displayed image held unchanged while freeze bit set.
// R13: Memory byte: odd line upper nibble, even line lower nibble.
// R14: Pointer write with top bit copies data; clear loads data.
// R15: Charge pump and display disabled switches generation off.
//
// Design decision made here: the Avalon-MM interface to the registers.
module lbpc_core #(
	parameter int REF_W = 8,
	parameter logic [REF_W-1:0] VREF_CODE = 8'hc0
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [9:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic SLEEP_STATE,
	output logic DISPLAY_ON,
	output logic PUMP_RUN,
	output logic LADDER_SELECT,
	output logic [3:0] FRAME_DIV,
	output logic [3:0] COMMON_USED,
	output logic [28:0] SEGMENT_ACTIVE,
	output logic [3:0] SEG_STATE [0:28],
	output lbpc_pkg::lbpc_rails_s RAILS
);

	// Registers are one byte wide, so only an eight-bit code fits.
	if (REF_W != 8) begin : g_ref_w_check
		$error("REF_W must be 8");
	end

	// ----------------------------------------------------------------
	// Storage.
	// ----------------------------------------------------------------
	logic [7:0] main_cfg_r;
	logic [7:0] clk_cfg_r;
	logic [7:0] volt_cfg_r;
	logic [7:0] seg_en_a_r;
	logic [7:0] seg_en_b_r;
	logic [7:0] power_cfg_r;
	logic [7:0] freeze_r;
	logic [7:0] ptr_r;
	logic [7:0] data_r;
	logic [7:0] seg_mem [0:lbpc_pkg::MEM_DEPTH-1];
	logic [7:0] shown [0:lbpc_pkg::MEM_DEPTH-1];
	lbpc_pkg::lbpc_bus_e bus_r;
	logic [31:0] rdata_nxt;
	logic [7:0] idx;
	logic hit_wr;
	logic hit_rd;

	// Register index from the byte address.
	function automatic logic [7:0] word_index(input logic [9:0] a);
		word_index = a[9:2];
	endfunction : word_index

	// Byte lane zero carries every register.
	function automatic logic wr_to(input logic [7:0] reg_idx);
		wr_to = hit_wr && (idx == reg_idx) && AVS_BYTEENABLE[0];
	endfunction : wr_to

	assign idx = word_index(AVS_ADDRESS);
	assign hit_wr = AVS_WRITE && (bus_r == lbpc_pkg::LBPC_IDLE);
	assign hit_rd = AVS_READ && (bus_r == lbpc_pkg::LBPC_IDLE);

	// ----------------------------------------------------------------
	// Avalon handshake: one wait state, answer on the second edge.
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			bus_r <= lbpc_pkg::LBPC_IDLE;
			AVS_WAITREQUEST <= 1'b1;
		end else begin
			case (bus_r)
			lbpc_pkg::LBPC_IDLE: begin
				if (AVS_READ || AVS_WRITE) begin
					bus_r <= lbpc_pkg::LBPC_ACK;
					AVS_WAITREQUEST <= 1'b0;
				end else begin
					AVS_WAITREQUEST <= 1'b1;
				end
			end
			lbpc_pkg::LBPC_ACK: begin
				bus_r <= lbpc_pkg::LBPC_IDLE;
				AVS_WAITREQUEST <= 1'b1;
			end
			default: begin
				bus_r <= lbpc_pkg::LBPC_IDLE;
				AVS_WAITREQUEST <= 1'b1;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Plain configuration registers. None of them is touched by the
	// display going off, so the previous setup comes straight back.
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			main_cfg_r <= lbpc_pkg::RST_BYTE;
			clk_cfg_r <= lbpc_pkg::RST_BYTE;
			volt_cfg_r <= lbpc_pkg::RST_BYTE; // R3
			seg_en_a_r <= lbpc_pkg::RST_BYTE;
			seg_en_b_r <= lbpc_pkg::RST_BYTE;
			power_cfg_r <= lbpc_pkg::RST_BYTE;
			freeze_r <= lbpc_pkg::RST_BYTE;
		end else begin
			if (wr_to(lbpc_pkg::IDX_MAIN_CFG)) begin
				main_cfg_r <= AVS_WRITEDATA[7:0]; // R7
			end
			if (wr_to(lbpc_pkg::IDX_CLK_CFG)) begin
				clk_cfg_r <= AVS_WRITEDATA[7:0];
			end
			if (wr_to(lbpc_pkg::IDX_VOLT_CFG)) begin
				volt_cfg_r <= AVS_WRITEDATA[7:0]; // R1
			end
			if (wr_to(lbpc_pkg::IDX_SEG_EN_A)) begin
				seg_en_a_r <= AVS_WRITEDATA[7:0];
			end
			if (wr_to(lbpc_pkg::IDX_SEG_EN_B)) begin
				seg_en_b_r <= AVS_WRITEDATA[7:0];
			end
			if (wr_to(lbpc_pkg::IDX_POWER_CFG)) begin
				power_cfg_r <= AVS_WRITEDATA[7:0]; // R6
			end
			if (wr_to(lbpc_pkg::IDX_FREEZE)) begin
				freeze_r <= AVS_WRITEDATA[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Indirect segment memory through pointer and data registers.
	// The memory has no reset, which also keeps it across display off.
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ptr_r <= lbpc_pkg::RST_BYTE;
			data_r <= lbpc_pkg::RST_BYTE;
		end else if (wr_to(lbpc_pkg::IDX_SEG_PTR)) begin
			ptr_r <= AVS_WRITEDATA[7:0];
			if (!AVS_WRITEDATA[lbpc_pkg::BIT_PTR_WRITE]) begin
				data_r <= (AVS_WRITEDATA[3:0] < 4'(lbpc_pkg::MEM_DEPTH))
				    ? seg_mem[AVS_WRITEDATA[3:0]] : lbpc_pkg::RST_BYTE; // R14
			end
		end else if (wr_to(lbpc_pkg::IDX_SEG_DATA)) begin
			data_r <= AVS_WRITEDATA[7:0];
		end
	end

	// Pointer write with the top bit set stores the data register.
	always_ff @(posedge CLK) begin
		if (wr_to(lbpc_pkg::IDX_SEG_PTR) &&
		    AVS_WRITEDATA[lbpc_pkg::BIT_PTR_WRITE] &&
		    (AVS_WRITEDATA[3:0] < 4'(lbpc_pkg::MEM_DEPTH))) begin
			seg_mem[AVS_WRITEDATA[3:0]] <= data_r; // R14 R7
		end
	end

	// Shadow copy drives the glass; it follows memory only while not
	// frozen, so a half-written image never reaches the pins.
	always_ff @(posedge CLK) begin
		if (!freeze_r[lbpc_pkg::BIT_FREEZE]) begin
			shown <= seg_mem; // R12
		end
	end

	// Odd lines take the upper nibble, even lines the lower one.
	always_ff @(posedge CLK) begin
		for (int s = 0; s < lbpc_pkg::TOTAL_SEGS; s++) begin
			SEG_STATE[s] <= s[0] ? shown[s >> 1][7:4]
			    : shown[s >> 1][3:0]; // R13
		end
	end

	// ----------------------------------------------------------------
	// Pin function assignment.
	// ----------------------------------------------------------------
	logic [12:0] upper_en;
	logic four_way;
	assign upper_en = {seg_en_b_r[4:0], seg_en_a_r};
	assign four_way = main_cfg_r[lbpc_pkg::LMUX_LSB +: 2] == lbpc_pkg::MUX_FOUR;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			SEGMENT_ACTIVE <= '0;
			COMMON_USED <= '0;
		end else begin
			SEGMENT_ACTIVE[lbpc_pkg::FIXED_SEGS-1:0] <= '1; // R8
			SEGMENT_ACTIVE[28:16] <= upper_en; // R10
			COMMON_USED <= four_way ? 4'hf : 4'h3; // R9
			if (four_way) begin
				SEGMENT_ACTIVE[28:27] <= 2'h0; // R9
			end
		end
	end

	// ----------------------------------------------------------------
	// Power and voltage control.
	// ----------------------------------------------------------------
	logic disp_en;
	logic disp_on_nxt;
	logic pump_nxt;
	assign disp_en = main_cfg_r[lbpc_pkg::BIT_DISP_EN];

	// In sleep the display also needs the reference kept alive.
	always_comb begin
		if (SLEEP_STATE) begin
			disp_on_nxt = !main_cfg_r[lbpc_pkg::BIT_SLEEP_BLOCK] && disp_en &&
			    power_cfg_r[lbpc_pkg::BIT_REF_KEEP]; // R5 R6
		end else begin
			disp_on_nxt = disp_en;
		end
		pump_nxt = !volt_cfg_r[lbpc_pkg::BIT_EXT_LADDER] && disp_on_nxt; // R15
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			DISPLAY_ON <= 1'b0;
			PUMP_RUN <= 1'b0;
			LADDER_SELECT <= 1'b0;
			FRAME_DIV <= 4'h0;
		end else begin
			DISPLAY_ON <= disp_on_nxt; // R5
			PUMP_RUN <= pump_nxt; // R15 R4
			LADDER_SELECT <= volt_cfg_r[lbpc_pkg::BIT_EXT_LADDER]; // R4
			FRAME_DIV <= clk_cfg_r[lbpc_pkg::FRAME_DIV_LSB +:
			    lbpc_pkg::FRAME_DIV_W]; // R11
		end
	end

	// Rails are forced to zero unless the pump runs, so the contrast
	// field has no effect with the ladder selected.
	lbpc_rail_calc #(
		.REF_W(REF_W)
	) u_rails (
		.clk(CLK),
		.rst_n(RST_N),
		.vref_code(VREF_CODE),
		.contrast(volt_cfg_r[lbpc_pkg::CONTRAST_W-1:0]), // R1
		.third_bias(main_cfg_r[lbpc_pkg::BIT_BIAS_THIRD]),
		.run(pump_nxt), // R4
		.rails(RAILS)
	);

	// ----------------------------------------------------------------
	// Read mux.
	// ----------------------------------------------------------------
	always_comb begin
		case (idx)
		lbpc_pkg::IDX_MAIN_CFG: rdata_nxt = {24'h0, main_cfg_r};
		lbpc_pkg::IDX_CLK_CFG: rdata_nxt = {24'h0, clk_cfg_r};
		lbpc_pkg::IDX_SEG_EN_A: rdata_nxt = {24'h0, seg_en_a_r};
		lbpc_pkg::IDX_VOLT_CFG: rdata_nxt = {24'h0, volt_cfg_r};
		lbpc_pkg::IDX_SEG_PTR: rdata_nxt = {24'h0, ptr_r};
		lbpc_pkg::IDX_SEG_DATA: rdata_nxt = {24'h0, data_r};
		lbpc_pkg::IDX_FREEZE: rdata_nxt = {24'h0, freeze_r};
		lbpc_pkg::IDX_SEG_EN_B: rdata_nxt = {24'h0, seg_en_b_r};
		lbpc_pkg::IDX_POWER_CFG: rdata_nxt = {24'h0, power_cfg_r};
		lbpc_pkg::IDX_STATUS: rdata_nxt = {29'h0, LADDER_SELECT, PUMP_RUN,
		    DISPLAY_ON};
		default: rdata_nxt = lbpc_pkg::UNMAPPED_READ;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			AVS_READDATA <= '0;
		end else if (hit_rd) begin
			AVS_READDATA <= rdata_nxt;
		end
	end

endmodule : lbpc_core

// >>> lbpc_monitor.sv
// --------------------------------------------------------------
// Port checker.
// --------------------------------------------------------------
module lbpc_monitor (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic AVS_WAITREQUEST,
	input wire logic DISPLAY_ON,
	input wire logic PUMP_RUN,
	input wire logic LADDER_SELECT,
	input wire logic [3:0] COMMON_USED,
	input wire logic [28:0] SEGMENT_ACTIVE,
	input wire lbpc_pkg::lbpc_rails_s RAILS
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	// Outputs lag reset release by one edge, hence the past guards.
	AST_FIXED_SEGS: assert property (
		$past(RST_N) |-> SEGMENT_ACTIVE[15:0] == 16'hffff)
		else $error("fixed segment pins inactive");
	AST_FOUR_WAY: assert property (
		COMMON_USED == 4'hf |-> SEGMENT_ACTIVE[28:27] == 2'h0)
		else $error("shared pins used as segments");
	AST_COMMONS: assert property (
		$past(RST_N) |-> COMMON_USED == 4'hf || COMMON_USED == 4'h3)
		else $error("bad common set");
	AST_RAIL_OFF: assert property (
		!PUMP_RUN [*3] |-> RAILS == '0)
		else $error("rails driven with pump off");
	AST_LADDER: assert property (
		LADDER_SELECT [*3] |-> !PUMP_RUN)
		else $error("pump runs with ladder");
	AST_DARK: assert property (
		!DISPLAY_ON [*3] |-> !PUMP_RUN)
		else $error("pump runs with display off");
	AST_ANSWER: assert property (
		$rose(AVS_READ || AVS_WRITE) |-> ##1 !AVS_WAITREQUEST)
		else $error("late bus answer");
	AST_ONE_CYCLE: assert property (
		!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("answer longer than one cycle");
	AST_IDLE: assert property (
		!(AVS_READ || AVS_WRITE) |=> AVS_WAITREQUEST)
		else $error("answer without request");

	C_ON: cover property (DISPLAY_ON && PUMP_RUN);
	C_LADDER: cover property (DISPLAY_ON && LADDER_SELECT);
	C_FOUR: cover property (COMMON_USED == 4'hf);
endmodule : lbpc_monitor

bind lbpc_core lbpc_monitor u_mon (
	.CLK(CLK),
	.RST_N(RST_N),
	.AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE),
	.AVS_WAITREQUEST(AVS_WAITREQUEST),
	.DISPLAY_ON(DISPLAY_ON),
	.PUMP_RUN(PUMP_RUN),
	.LADDER_SELECT(LADDER_SELECT),
	.COMMON_USED(COMMON_USED),
	.SEGMENT_ACTIVE(SEGMENT_ACTIVE),
	.RAILS(RAILS)
);

// >>> lbpc_glass.sv
// --------------------------------------------------------------
// Glass model: visible only with a voltage source behind it.
// --------------------------------------------------------------
module lbpc_glass (
	input wire logic display_on,
	input wire logic ladder,
	input wire lbpc_pkg::lbpc_rails_s rails,
	output logic lit
);
	// The ladder feeds the glass itself; otherwise rails must be up.
	always_comb lit = display_on && (ladder || |rails);
endmodule : lbpc_glass

// >>> lcd_bias_power_control_test.sv
// --------------------------------------------------------------
// Self-checking bench.
// --------------------------------------------------------------
module lcd_bias_power_control_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [9:0] addr = 10'h000;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic sleep = 1'b0;
	logic [31:0] rdata;
	logic wreq, disp_on, pump, ladder, lit;
	logic [3:0] fdiv, commons;
	logic [28:0] seg_act;
	logic [3:0] seg_state [0:28];
	lbpc_pkg::lbpc_rails_s rails;
	logic [31:0] seed = 32'h3f72;
	logic [7:0] q;
	logic [31:0] a, b, c;
	int n_mismatch = 0;
	int total_checks = 0;
	int mem [15];
	int shown [15];
	int e;

	// Free-running 25 MHz clock.
	always #20 clk = ~clk;

	lbpc_core u_dut (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
		.AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(wreq), .SLEEP_STATE(sleep),
		.DISPLAY_ON(disp_on), .PUMP_RUN(pump), .LADDER_SELECT(ladder),
		.FRAME_DIV(fdiv), .COMMON_USED(commons), .SEGMENT_ACTIVE(seg_act),
		.SEG_STATE(seg_state), .RAILS(rails));
	lbpc_glass u_glass (.display_on(disp_on), .ladder(ladder),
		.rails(rails), .lit(lit));

	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict

	task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, x, g);
		end
	endtask : chk

	// One Avalon access; the request holds until waitrequest is low.
	task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int n;
		@(posedge clk);
		addr <= {idx, 2'h0};
		wdata <= {24'h0, d};
		wr <= w;
		rd <= !w;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 100);
		q = rdata[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 100) begin
			n_mismatch++;
			print_verdict();
		end
	endtask : bus

	// Even line in the low nibble, odd line in the high nibble.
	task seg_cmp();
		for (int k = 0; k < 15; k++) begin
			chk("seg_even", shown[k] & 15, seg_state[2*k]);
			if (k < 14)
				chk("seg_odd", shown[k] >> 4, seg_state[2*k+1]);
		end
	endtask : seg_cmp

	// Main sequence.
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		bus(0, lbpc_pkg::IDX_VOLT_CFG, 8'h00);
		chk("volt_cfg", 0, rdata);
		bus(0, 8'h00, 8'h00);
		chk("unmapped", 0, rdata);
		for (int p = 0; p < 2; p++) begin
			bus(1, lbpc_pkg::IDX_FREEZE, 8'h01);
			for (int k = 0; k < 15; k++) begin
				mem[k] = int'(xs() & 255);
				bus(1, lbpc_pkg::IDX_SEG_DATA, mem[k][7:0]);
				bus(1, lbpc_pkg::IDX_SEG_PTR, 8'h80 | k[7:0]);
				bus(1, lbpc_pkg::IDX_SEG_DATA, ~mem[k][7:0]);
				bus(1, lbpc_pkg::IDX_SEG_PTR, k[7:0]);
				bus(0, lbpc_pkg::IDX_SEG_DATA, 8'h00);
				chk("mem", mem[k], q);
			end
			repeat (4) @(posedge clk);
			if (p > 0)
				seg_cmp();
			bus(1, lbpc_pkg::IDX_FREEZE, 8'h00);
			repeat (4) @(posedge clk);
			shown = mem;
			seg_cmp();
			$display("memory pass %0d done", p);
		end
		bus(1, lbpc_pkg::IDX_POWER_CFG, 8'h08);
		bus(1, lbpc_pkg::IDX_CLK_CFG, 8'h0f);
		a = xs();
		b = xs();
		bus(1, lbpc_pkg::IDX_SEG_EN_A, a[7:0]);
		bus(1, lbpc_pkg::IDX_SEG_EN_B, b[7:0]);
		// Bits: 0 ladder, 1 enable, 2 sleep block, 3 sleep, 4 four-way.
		for (int m = 0; m < 32; m++) begin
			c = xs();
			sleep <= m[3];
			bus(1, lbpc_pkg::IDX_MAIN_CFG, {m[1], 2'h2, m[2], 2'h0, m[4], 1'b1});
			bus(1, lbpc_pkg::IDX_VOLT_CFG, {1'b0, m[0], c[5:0]});
			bus(0, lbpc_pkg::IDX_VOLT_CFG, 8'h00);
			chk("volt_rb", {m[0], c[5:0]}, rdata);
			repeat (4) @(posedge clk);
			e = m[1] && !(m[3] && m[2]);
			chk("display_on", e, disp_on);
			chk("pump_run", e && !m[0], pump);
			chk("lit", e, lit);
			chk("ladder", m[0], ladder);
			chk("commons", m[4] ? 15 : 3, commons);
			// One-third bias spaces the rails strictly; they are all zero
			// whenever the pump is stopped.
			chk("rail_order", e && !m[0], rails.rail_a < rails.rail_b &&
				rails.rail_b < rails.rail_c);
			chk("seg_act", {m[4] ? 2'h0 : b[4:3], b[2:0], a[7:0],
				16'hffff}, seg_act);
			chk("frame_div", 15, fdiv);
			bus(0, lbpc_pkg::IDX_STATUS, 8'h00);
			chk("status", {m[0], e[0] && !m[0], e[0]}, q);
		end
		$display("display modes done");
		seg_cmp();
		$display("retention done");
		print_verdict();
	end
endmodule : lcd_bias_power_control_test
